/* File: inc/pkc_pkg.sv */
// Shared constants and types for the packet command chaining block.
// Assumes a single 25 MHz core clock and byte-wide packet data.
`default_nettype none
package pkc_pkg;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int CLK_NS = 40;
   localparam int GAP_NS = 200;
   // Least idle time of an interrupt, rounded up to whole cycles
   localparam int GAP_CYC = (GAP_NS + CLK_NS - 1) / CLK_NS;
   localparam logic [2:0] GAP_LOAD = 3'(GAP_CYC);

   // ------------------------------------------------------------
   // Configuration byte and page layout
   // ------------------------------------------------------------
   localparam int CHAIN_BIT = 6;
   localparam logic [8:0] SRC_ID_LOC = 9'h000;
   localparam logic [8:0] DST_ID_LOC = 9'h001;
   localparam logic [8:0] SHORT_CNT_LOC = 9'h002;
   localparam logic [8:0] LONG_CNT_LOC = 9'h003;
   localparam logic [8:0] PAGE_LAST = 9'h1FF;
   localparam int PAGE_AW = 9;
   localparam int FIFO_DEPTH = 8;

   // ------------------------------------------------------------
   // Commands from the microcontroller
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PKC_CMD_NONE,
      PKC_CMD_EN_TX,
      PKC_CMD_EN_RX,
      PKC_CMD_DIS_TX,
      PKC_CMD_DIS_RX,
      PKC_CMD_CLR_TX,
      PKC_CMD_CLR_RX
   } pkc_cmd_t;
endpackage : pkc_pkg
`default_nettype wire

/* File: design/pkc_chain.sv */
// Command and status logic: receive into paged RAM, two-deep command
// chaining for transmit and receive, double-buffered status, irq paced in chaining only.
// Assumes the network engine pulses token_seen and tx_done, and feeds
// received bytes as a valid/ready stream with a last marker.
`timescale 1ns/100ps
`default_nettype none

// ------------------------------------------------------------
// Receive byte buffer
// ------------------------------------------------------------
module pkc_fifo #(
   parameter int W = 9,
   parameter int D = 8
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [W-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [W-1:0] out_data
);
   localparam int AW = $clog2(D);
   if (D < 2 || (1 << AW) != D) begin : g_chk
      $error("pkc_fifo depth must be a power of two");
   end
   logic [W-1:0] mem [D];
   logic [AW:0] wr_ptr;
   logic [AW:0] rd_ptr;

   // Pointer wrap bit tells full from empty
   assign in_ready = (wr_ptr ^ rd_ptr) != {1'b1, {AW{1'b0}}};
   assign out_valid = wr_ptr != rd_ptr;
   assign out_data = mem[rd_ptr[AW-1:0]];

   // Storage
   always_ff @(posedge clk) begin
      if (in_valid && in_ready) begin
         mem[wr_ptr[AW-1:0]] <= in_data;
      end
   end

   // Pointers
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_ptr <= '0;
         rd_ptr <= '0;
      end else begin
         if (in_valid && in_ready) begin
            wr_ptr <= wr_ptr + 1'b1;
         end
         if (out_valid && out_ready) begin
            rd_ptr <= rd_ptr + 1'b1;
         end
      end
   end
endmodule : pkc_fifo

// ------------------------------------------------------------
// Command interpreter
// ------------------------------------------------------------
module pkc_chain #(
   parameter int PAGES = 4
) (
   input wire logic clk,
   input wire logic resetn,
   input wire logic [7:0] config_byte,
   input wire logic long_en,
   input wire logic mask_tx,
   input wire logic mask_rx,
   input wire logic cmd_valid,
   input wire pkc_pkg::pkc_cmd_t cmd_op,
   input wire logic [$clog2(PAGES)-1:0] cmd_page,
   input wire logic token_seen,
   output logic tx_go,
   output logic [$clog2(PAGES)-1:0] tx_page,
   input wire logic tx_done,
   input wire logic tx_ok,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   input wire logic rx_last,
   output logic rx_ready,
   input wire logic [$clog2(PAGES)+8:0] rd_addr,
   output logic [7:0] rd_data,
   output logic fbe_nak,
   output logic transmitter_free_flag,
   output logic transmit_ack_flag,
   output logic receiver_inhibited_flag,
   output logic transmit_done_edge_flag,
   output logic receive_done_edge_flag,
   output logic irq
);
   import pkc_pkg::*;
   localparam int PW = $clog2(PAGES);
   if (PAGES < 2 || (1 << PW) != PAGES) begin : g_chk
      $error("pkc_chain page count must be a power of two");
   end

   logic [7:0] mem [PAGES << PAGE_AW];
   logic chain;
   logic [1:0] cap;
   logic c_entx, c_enrx, c_distx, c_disrx, c_clrtx, c_clrrx;
   logic [PW-1:0] tx_q [2];
   logic [PW-1:0] rx_q [2];
   logic [1:0] tx_cnt, rx_cnt, txs_cnt, rxs_cnt;
   logic [1:0] next_tx_cnt, next_rx_cnt;
   logic tx_busy, tx_push, tx_pop, tx_fin;
   logic rx_push, rx_pop, rx_fin, rx_active;
   logic [1:0] txs_ack;
   logic [2:0] tx_gap, rx_gap;
   logic tx_clear, rx_clear;
   logic f_valid, f_ready, f_last, wr_fire, long_pkt;
   logic [7:0] f_data;
   logic [8:0] wr_addr;
   logic [2:0] pos;

   // ------------------------------------------------------------
   // Command decode
   // ------------------------------------------------------------
   // chaining from bit 6
   assign chain = config_byte[CHAIN_BIT];
   assign cap = chain ? 2'h2 : 2'h1;
   assign c_entx = cmd_valid && cmd_op == PKC_CMD_EN_TX;
   assign c_enrx = cmd_valid && cmd_op == PKC_CMD_EN_RX;
   assign c_distx = cmd_valid && cmd_op == PKC_CMD_DIS_TX;
   assign c_disrx = cmd_valid && cmd_op == PKC_CMD_DIS_RX;
   assign c_clrtx = cmd_valid && cmd_op == PKC_CMD_CLR_TX;
   assign c_clrrx = cmd_valid && cmd_op == PKC_CMD_CLR_RX;

   // ------------------------------------------------------------
   // Transmit command queue
   // ------------------------------------------------------------
   // second command kept with page
   assign tx_push = c_entx && tx_cnt < cap;
   assign tx_fin = tx_done && tx_busy;
   // cancel drops the oldest only; one in flight is left alone
   assign tx_pop = tx_fin || (c_distx && tx_cnt != 2'h0 && !tx_busy);
   assign next_tx_cnt = tx_cnt + 2'(tx_push) - 2'(tx_pop);
   assign tx_page = tx_q[0];

   // Queue entries; a later write to the same slot wins the shift
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_q[0] <= '0;
         tx_q[1] <= '0;
      end else begin
         if (tx_pop) begin
            tx_q[0] <= tx_q[1];
         end
         if (tx_push) begin
            tx_q[1'(tx_cnt - 2'(tx_pop))] <= cmd_page;
         end
      end
   end

   // Count and transmitter free level
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_cnt <= 2'h0;
         transmitter_free_flag <= 1'b1;
      end else begin
         tx_cnt <= next_tx_cnt;
         transmitter_free_flag <= next_tx_cnt == 2'h0;
      end
   end

   // start on token; in chaining held back while both status slots are full
   always_ff @(posedge clk) begin
      if (!resetn) begin
         tx_go <= 1'b0;
         tx_busy <= 1'b0;
      end else begin
         tx_go <= 1'b0;
         if (tx_fin) begin
            tx_busy <= 1'b0;
         end else if (token_seen && tx_cnt != 2'h0 && !tx_busy &&
               (!chain || txs_cnt != 2'h2)) begin
            tx_go <= 1'b1;
            tx_busy <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Transmit status queue and edge flag
   // ------------------------------------------------------------
   assign tx_clear = c_clrtx && transmit_done_edge_flag;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         txs_ack <= 2'h0;
         txs_cnt <= 2'h0;
      end else begin
         // Saturates: plain mode never clears, so the count must not wrap
         txs_cnt <= txs_cnt + 2'(tx_fin && txs_cnt != 2'h2) - 2'(tx_clear);
         if (tx_clear) begin
            txs_ack[0] <= txs_ack[1];
         end
         if (tx_fin) begin
            txs_ack[1'(txs_cnt - 2'(tx_clear))] <= tx_ok;
         end
      end
   end

   // held until cleared, then idle gap before the next
   always_ff @(posedge clk) begin
      if (!resetn) begin
         transmit_done_edge_flag <= 1'b0;
         tx_gap <= 3'h0;
      end else if (tx_clear) begin
         transmit_done_edge_flag <= 1'b0;
         tx_gap <= GAP_LOAD;
      end else begin
         if (tx_gap != 3'h0) begin
            tx_gap <= tx_gap - 3'h1;
         end
         // raised only by a stored completion
         if (!transmit_done_edge_flag && txs_cnt != 2'h0 && tx_gap == 3'h0) begin
            transmit_done_edge_flag <= 1'b1;
         end
      end
   end

   // Ack level shows the reported transmission's result
   always_ff @(posedge clk) begin
      if (!resetn) begin
         transmit_ack_flag <= 1'b0;
      end else if (tx_push && tx_cnt == 2'h0 && !chain) begin
         transmit_ack_flag <= 1'b0;
      end else if (tx_fin && !chain) begin
         transmit_ack_flag <= tx_ok;
      end else if (chain && tx_clear) begin
         transmit_ack_flag <= 1'b0;
      end else if (chain && !transmit_done_edge_flag && txs_cnt != 2'h0 && tx_gap == 3'h0) begin
         transmit_ack_flag <= txs_ack[0];
      end
   end

   // ------------------------------------------------------------
   // Receive command queue
   // ------------------------------------------------------------
   assign rx_push = c_enrx && rx_cnt < cap;
   // a reception in progress cannot be cancelled
   assign rx_pop = rx_fin || (c_disrx && rx_cnt != 2'h0 && !rx_active);
   assign next_rx_cnt = rx_cnt + 2'(rx_push) - 2'(rx_pop);
   assign fbe_nak = receiver_inhibited_flag;

   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_q[0] <= '0;
         rx_q[1] <= '0;
      end else begin
         if (rx_pop) begin
            rx_q[0] <= rx_q[1];
         end
         if (rx_push) begin
            rx_q[1'(rx_cnt - 2'(rx_pop))] <= cmd_page;
         end
      end
   end

   // Count and receiver inhibited level
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rx_cnt <= 2'h0;
         receiver_inhibited_flag <= 1'b1;
      end else begin
         rx_cnt <= next_rx_cnt;
         // set whenever the queue empties: its last byte stored, or its last page cancelled
         receiver_inhibited_flag <= next_rx_cnt == 2'h0;
      end
   end

   // ------------------------------------------------------------
   // Receive data path
   // ------------------------------------------------------------
   // Draining stalls with no page or, in chaining, both status slots full,
   // so the buffer fills and rx_ready drops back to the engine.
   assign f_ready = rx_cnt != 2'h0 && (!chain || rxs_cnt != 2'h2);
   assign wr_fire = f_valid && f_ready;
   assign rx_fin = wr_fire && f_last;

   pkc_fifo #(
      .W(9),
      .D(FIFO_DEPTH)
   ) u_fifo (
      .clk(clk),
      .resetn(resetn),
      .in_valid(rx_valid),
      .in_ready(rx_ready),
      .in_data({rx_last, rx_data}),
      .out_valid(f_valid),
      .out_ready(f_ready),
      .out_data({f_last, f_data})
   );

   // bytes stored into the selected page
   always_ff @(posedge clk) begin
      if (wr_fire) begin
         mem[{rx_q[0], wr_addr}] <= f_data;
      end
   end

   // Read port for the microcontroller
   always_ff @(posedge clk) begin
      rd_data <= mem[rd_addr];
   end

   // Write address walks the sender's layout
   always_ff @(posedge clk) begin
      if (!resetn) begin
         wr_addr <= SRC_ID_LOC;
         pos <= 3'h0;
         long_pkt <= 1'b0;
         rx_active <= 1'b0;
      end else if (rx_fin) begin
         wr_addr <= SRC_ID_LOC;
         pos <= 3'h0;
         long_pkt <= 1'b0;
         rx_active <= 1'b0;
      end else if (wr_fire) begin
         rx_active <= 1'b1;
         if (pos != 3'h4) begin
            pos <= pos + 3'h1;
         end
         if (pos == 3'h2) begin
            // zero count marks a long packet
            if (long_en && f_data == 8'h00) begin
               long_pkt <= 1'b1;
               wr_addr <= LONG_CNT_LOC;
            end else begin
               wr_addr <= {1'b0, f_data};
            end
         end else if (pos == 3'h3 && long_pkt) begin
            // long count gives the data start
            wr_addr <= {1'b0, f_data};
         end else if (wr_addr != PAGE_LAST) begin
            wr_addr <= wr_addr + 9'h001;
         end
      end
   end

   // ------------------------------------------------------------
   // Receive status and edge flag
   // ------------------------------------------------------------
   assign rx_clear = c_clrrx && receive_done_edge_flag;

   // completions waiting to be reported; a set and a clear in one cycle cancel out, except at 2 where the clear wins
   always_ff @(posedge clk) begin
      if (!resetn) begin
         rxs_cnt <= 2'h0;
      end else begin
         // Saturates: plain mode never clears, so the count must not wrap
         rxs_cnt <= rxs_cnt + 2'(rx_fin && rxs_cnt != 2'h2) - 2'(rx_clear);
      end
   end

   always_ff @(posedge clk) begin
      if (!resetn) begin
         receive_done_edge_flag <= 1'b0;
         rx_gap <= 3'h0;
      end else if (rx_clear) begin
         receive_done_edge_flag <= 1'b0;
         rx_gap <= GAP_LOAD;
      end else begin
         if (rx_gap != 3'h0) begin
            rx_gap <= rx_gap - 3'h1;
         end
         // raised only by a stored reception
         if (!receive_done_edge_flag && rxs_cnt != 2'h0 && rx_gap == 3'h0) begin
            receive_done_edge_flag <= 1'b1;
         end
      end
   end

   // ------------------------------------------------------------
   // Interrupt
   // ------------------------------------------------------------
   // masks gate edge flags in chaining, levels otherwise
   assign irq = chain ?
      (transmit_done_edge_flag && mask_tx) || (receive_done_edge_flag && mask_rx) :
      (transmitter_free_flag && mask_tx) || (receiver_inhibited_flag && mask_rx);

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence s_tx_cleared;
      c_clrtx && transmit_done_edge_flag;
   endsequence
   sequence s_tx_idle;
      !transmit_done_edge_flag [*5];
   endsequence

   a_ri_enable_clear: assert property (rx_push && rx_cnt == 2'h0 |=>
      !receiver_inhibited_flag) else $error("enable receive left inhibit set");
   a_ri_done_set: assert property (rx_fin && rx_cnt == 2'h1 && !rx_push |=>
      receiver_inhibited_flag) else $error("inhibit not set after packet");
   a_irq_level_gate: assert property (!chain && transmitter_free_flag && mask_tx
      |-> irq) else $error("level irq missing");
   a_irq_edge_only: assert property (chain && !transmit_done_edge_flag
      && !receive_done_edge_flag |-> !irq) else $error("chained irq without edge flag");
   a_tx_enable_clear: assert property (tx_push && tx_cnt == 2'h0 |=>
      !transmitter_free_flag) else $error("free flag not cleared");
   a_tde_held: assert property (transmit_done_edge_flag && !c_clrtx |=>
      transmit_done_edge_flag) else $error("edge flag dropped without clear");
   a_irq_gap_tx: assert property (s_tx_cleared |=> s_tx_idle)
      else $error("transmit flag gap too short");
   a_long_detect: assert property (wr_fire && pos == 3'h2 && long_en
      && f_data == 8'h00 && !f_last |=> wr_addr == LONG_CNT_LOC)
      else $error("long packet not detected");
   a_tx_cancel_one: assert property (c_distx && tx_cnt == 2'h2 && !tx_busy
      && !tx_push |=> tx_cnt == 2'h1) else $error("cancel removed wrong count");
   a_rx_cancel_busy: assert property (c_disrx && rx_active && !rx_fin && !rx_push
      |=> rx_cnt == $past(rx_cnt)) else $error("started reception cancelled");
   a_tde_raise: assert property (tx_fin && txs_cnt == 2'h0 && !transmit_done_edge_flag
      && tx_gap == 3'h0 |-> ##2 transmit_done_edge_flag) else $error("done flag not raised");
endmodule : pkc_chain
`default_nettype wire

/* File: verification/pkc_engine_model.sv */
// Network engine stand-in: answers every tx_go with tx_done after DLY cycles.
// Assumes tx_go is a one-cycle pulse on the same clock as this model.
`timescale 1ns/100ps
`default_nettype none
module pkc_engine_model #(
   parameter int DLY = 4
) (
   input wire logic clk,
   input wire logic tx_go,
   input wire logic ok_in,
   output logic tx_done,
   output logic tx_ok
);
   int cnt = 0;
   initial tx_done = 1'b0;
   initial tx_ok = 1'b0;
   // ------------------------------------------------
   // Transmit answer
   // ------------------------------------------------
   // Outside tx_done the result line toggles, so a stale value never passes
   always @(posedge clk) begin
      tx_done <= 1'b0;
      tx_ok <= ~tx_ok;
      if (tx_go) begin
         cnt <= DLY;
      end else if (cnt == 1) begin
         cnt <= 0;
         tx_done <= 1'b1;
         tx_ok <= ok_in;
      end else if (cnt > 1) begin
         cnt <= cnt - 1;
      end
   end
endmodule : pkc_engine_model
`default_nettype wire

/* File: verification/pkc_chain_tb.sv */
// Self-checking bench for the command chaining block, one task per scenario.
// Assumes pkc_pkg is compiled first; the block runs with four pages.
`timescale 1ns/100ps
`default_nettype none
module pkc_chain_tb;
   import pkc_pkg::*;
   logic clk = 1'b0;
   logic resetn = 1'b0;
   logic [7:0] config_byte = 8'h00;
   logic long_en = 1'b0;
   logic mask_tx = 1'b0;
   logic mask_rx = 1'b0;
   logic cmd_valid = 1'b0;
   pkc_cmd_t cmd_op = PKC_CMD_NONE;
   logic [1:0] cmd_page = 2'h0;
   logic token_seen = 1'b0;
   logic ok_in = 1'b1;
   logic rx_valid = 1'b0;
   logic [7:0] rx_data = 8'h00;
   logic rx_last = 1'b0;
   logic [10:0] rd_addr = 11'h000;
   logic tx_go, tx_done, tx_ok, rx_ready, fbe_nak, irq;
   logic tx_free, tx_ack, rx_inh, tx_edge, rx_edge;
   logic [1:0] tx_page;
   logic [7:0] rd_data;
   int fails = 0;
   int samples_checked = 0;
   int w;

   // Clock of 40 ns
   always #20 clk = ~clk;

   pkc_chain #(.PAGES(4)) DUT (.clk(clk), .resetn(resetn), .config_byte(config_byte),
      .long_en(long_en), .mask_tx(mask_tx), .mask_rx(mask_rx), .cmd_valid(cmd_valid),
      .cmd_op(cmd_op), .cmd_page(cmd_page), .token_seen(token_seen), .tx_go(tx_go),
      .tx_page(tx_page), .tx_done(tx_done), .tx_ok(tx_ok), .rx_valid(rx_valid),
      .rx_data(rx_data), .rx_last(rx_last), .rx_ready(rx_ready), .rd_addr(rd_addr),
      .rd_data(rd_data), .fbe_nak(fbe_nak), .transmitter_free_flag(tx_free),
      .transmit_ack_flag(tx_ack), .receiver_inhibited_flag(rx_inh),
      .transmit_done_edge_flag(tx_edge), .receive_done_edge_flag(rx_edge), .irq(irq));

   pkc_engine_model #(.DLY(4)) engine (.clk(clk), .tx_go(tx_go), .ok_in(ok_in),
      .tx_done(tx_done), .tx_ok(tx_ok));

   // ------------------------------------------------
   // Helpers
   // ------------------------------------------------
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      samples_checked++;
      if (g !== e) begin
         fails++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Inputs always move 1 ns after the rising edge
   task automatic step;
      @(posedge clk);
      #1;
   endtask : step

   task automatic do_reset;
      resetn = 1'b0;
      config_byte = 8'h00;
      long_en = 1'b0;
      mask_tx = 1'b0;
      mask_rx = 1'b0;
      repeat (6) step();
      resetn = 1'b1;
   endtask : do_reset

   // Two cycles per command so the strobe never toggles twice in one step
   task automatic cmd(input pkc_cmd_t op, input logic [1:0] pg);
      cmd_valid = 1'b1;
      cmd_op = op;
      cmd_page = pg;
      step();
      cmd_valid = 1'b0;
      cmd_op = PKC_CMD_NONE;
      step();
   endtask : cmd

   task automatic tok(input logic [1:0] pg);
      token_seen = 1'b1;
      step();
      token_seen = 1'b0;
      chk("tx_go", 1, tx_go);
      chk("tx_page", pg, tx_page);
   endtask : tok

   function automatic logic [7:0] val(input int k, input logic [7:0] s, b2, b3);
      if (k == 0) return s;
      if (k == 1) return ~s;
      if (k == 2) return b2;
      if (k == 3 && b2 == 8'h00) return b3;
      return 8'(k * 3) ^ s;
   endfunction : val

   // Valid stays up across the whole packet; each byte waits for ready
   task automatic pkt(input int n, input logic [7:0] s, b2, b3);
      int i;
      rx_valid = 1'b1;
      for (int k = 0; k < n; k++) begin
         rx_data = val(k, s, b2, b3);
         rx_last = (k == n - 1);
         for (i = 0; i < 200 && rx_ready !== 1'b1; i++) step();
         step();
      end
      rx_valid = 1'b0;
      rx_last = 1'b0;
   endtask : pkt

   task automatic rd(input logic [1:0] pg, input logic [8:0] off, input logic [7:0] e);
      rd_addr = {pg, off};
      step();
      chk("rd_data", e, rd_data);
   endtask : rd

   // ------------------------------------------------
   // Scenarios
   // ------------------------------------------------
   task automatic t_reset_state;
      mask_tx = 1'b1;
      step();
      chk("tx_free", 1, tx_free);
      chk("rx_inh", 1, rx_inh);
      chk("edges", 0, {tx_edge, rx_edge});
      chk("tx_ack", 0, tx_ack);
      chk("fbe_nak", 1, fbe_nak);
      chk("irq level", 1, irq);
      mask_tx = 1'b0;
      step();
      chk("irq off", 0, irq);
   endtask : t_reset_state

   task automatic t_rx_short;
      do_reset();
      long_en = 1'b1;
      mask_rx = 1'b1;
      fork
         pkt(10, 8'h11, 8'hF9, 8'h00);
         begin
            repeat (20) step();
            chk("rx_ready full", 0, rx_ready);
            cmd(PKC_CMD_EN_RX, 2'h1);
            chk("rx_inh", 0, rx_inh);
            chk("fbe_nak", 0, fbe_nak);
            cmd(PKC_CMD_DIS_RX, 2'h0);
            chk("rx_inh busy", 0, rx_inh);
         end
      join
      chk("rx_inh early", 0, rx_inh);
      for (w = 0; w < 50 && rx_inh !== 1'b1; w++) step();
      chk("irq rx", 1, irq);
      mask_rx = 1'b0;
      step();
      chk("irq masked", 0, irq);
      chk("fbe_nak", 1, fbe_nak);
      rd(1, 9'h000, 8'h11);
      rd(1, 9'h001, 8'hEE);
      rd(1, 9'h002, 8'hF9);
      rd(1, 9'h0F9, val(3, 8'h11, 8'hF9, 8'h00));
      rd(1, 9'h0FF, val(9, 8'h11, 8'hF9, 8'h00));
   endtask : t_rx_short

   task automatic t_rx_long;
      do_reset();
      long_en = 1'b1;
      cmd(PKC_CMD_EN_RX, 2'h2);
      pkt(261, 8'h22, 8'h00, 8'hFF);
      for (w = 0; w < 50 && rx_inh !== 1'b1; w++) step();
      rd(2, 9'h002, 8'h00);
      rd(2, 9'h003, 8'hFF);
      rd(2, 9'h0FF, val(4, 8'h22, 8'h00, 8'hFF));
      rd(2, 9'h1FF, val(260, 8'h22, 8'h00, 8'hFF));
   endtask : t_rx_long

   task automatic t_plain_tx;
      do_reset();
      mask_tx = 1'b1;
      cmd(PKC_CMD_EN_TX, 2'h1);
      chk("tx_free", 0, tx_free);
      chk("irq busy", 0, irq);
      tok(2'h1);
      for (w = 0; w < 50 && tx_free !== 1'b1; w++) step();
      chk("tx_ack ok", 1, tx_ack);
      chk("irq free", 1, irq);
      ok_in = 1'b0;
      cmd(PKC_CMD_EN_TX, 2'h2);
      chk("tx_ack clr", 0, tx_ack);
      tok(2'h2);
      for (w = 0; w < 50 && tx_free !== 1'b1; w++) step();
      chk("tx_ack fail", 0, tx_ack);
      ok_in = 1'b1;
      // Plain mode never clears status, so a third send must not stall
      cmd(PKC_CMD_EN_TX, 2'h3);
      tok(2'h3);
   endtask : t_plain_tx

   task automatic t_chain_tx;
      do_reset();
      mask_tx = 1'b1;
      config_byte = 8'h40;
      step();
      chk("irq chain", 0, irq);
      cmd(PKC_CMD_EN_TX, 2'h2);
      chk("tx_free", 0, tx_free);
      cmd(PKC_CMD_EN_TX, 2'h3);
      tok(2'h2);
      for (w = 0; w < 50 && tx_edge !== 1'b1; w++) step();
      chk("tx_ack", 1, tx_ack);
      chk("irq tx", 1, irq);
      mask_tx = 1'b0;
      step();
      chk("irq masked", 0, irq);
      mask_tx = 1'b1;
      ok_in = 1'b0;
      tok(2'h3);
      repeat (12) step();
      chk("tx_edge held", 1, tx_edge);
      chk("tx_ack held", 1, tx_ack);
      cmd(PKC_CMD_CLR_TX, 2'h0);
      chk("irq gap", 0, irq);
      for (w = 0; w < 50 && tx_edge !== 1'b1; w++) step();
      chk("gap cycles", 1, w >= 5 && w < 50);
      chk("tx_ack 2nd", 0, tx_ack);
      cmd(PKC_CMD_CLR_TX, 2'h0);
      chk("tx_edge clr", 0, tx_edge);
      chk("tx_free", 1, tx_free);
      ok_in = 1'b1;
   endtask : t_chain_tx

   task automatic t_chain_cancel;
      do_reset();
      config_byte = 8'h40;
      cmd(PKC_CMD_EN_TX, 2'h1);
      cmd(PKC_CMD_EN_TX, 2'h2);
      cmd(PKC_CMD_EN_TX, 2'h3);
      cmd(PKC_CMD_DIS_TX, 2'h0);
      chk("tx_page", 2, tx_page);
      cmd(PKC_CMD_DIS_TX, 2'h0);
      chk("tx_free", 1, tx_free);
   endtask : t_chain_cancel

   task automatic t_chain_rx;
      do_reset();
      config_byte = 8'h40;
      mask_rx = 1'b1;
      cmd(PKC_CMD_EN_RX, 2'h0);
      cmd(PKC_CMD_EN_RX, 2'h1);
      cmd(PKC_CMD_EN_RX, 2'h3);
      cmd(PKC_CMD_DIS_RX, 2'h0);
      cmd(PKC_CMD_EN_RX, 2'h2);
      pkt(5, 8'h31, 8'hFE, 8'h00);
      for (w = 0; w < 50 && rx_edge !== 1'b1; w++) step();
      chk("irq rx", 1, irq);
      pkt(5, 8'h42, 8'hFE, 8'h00);
      for (w = 0; w < 50 && rx_inh !== 1'b1; w++) step();
      chk("rx_edge held", 1, rx_edge);
      rd(1, 9'h000, 8'h31);
      rd(2, 9'h000, 8'h42);
      mask_rx = 1'b0;
      step();
      chk("irq masked", 0, irq);
      mask_rx = 1'b1;
      cmd(PKC_CMD_CLR_RX, 2'h0);
      chk("rx_edge clr", 0, rx_edge);
      for (w = 0; w < 50 && rx_edge !== 1'b1; w++) step();
      chk("rx_edge 2nd", 1, rx_edge);
      cmd(PKC_CMD_CLR_RX, 2'h0);
      chk("irq clr", 0, irq);
   endtask : t_chain_rx

   // ------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------
   initial begin
      repeat (6) step();
      resetn = 1'b1;
      t_reset_state();
      t_rx_short();
      t_rx_long();
      t_plain_tx();
      t_chain_tx();
      t_chain_cancel();
      t_chain_rx();
      report_and_stop();
   end

   // The scenarios need a few hundred cycles; 20000 means a hang
   initial begin
      #800000;
      fails++;
      report_and_stop();
   end
endmodule : pkc_chain_tb
`default_nettype wire
